// file: fpd_controller.sv
// host-side controller for a 1M x 4 fast-page dram
// Functional notes
// - page accesses toggle column strobe, row held
// - refresh 1024 rows every 16 ms
// - random cycles spaced at least 160 ns
// - page column cycles at least 50 ns
// - row active 80 ns up to 125 us
// - column strobe 25 to 60 ns after row
// - column low 10 ns before row for refresh
// - column held 15 ns after row in refresh
// - 100 us pause then eight row cycles
// - write enable high during refresh
`include "fpd_map.svh"
`timescale 1ns/1ps
module fpd_controller #(
   parameter int PWRUP_CYC = `FPD_T_PWRUP_US * `FPD_CLK_MHZ,
   parameter int REF_INTERVAL_CYC = (`FPD_T_REF_MS * 1000 * `FPD_CLK_MHZ) / `FPD_ROWS,
   parameter int RASP_MAX_CYC = `FPD_CYC_MAX(`FPD_T_RASP_MAX_NS)
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // user request side
   input wire logic reqValid,
   output logic reqReady,
   input wire fpd_pkg::fpd_req_t req,
   output logic rdValid,
   output logic [`FPD_DATA_W-1:0] rdData,
   output logic initDone,
   // dram pins
   output fpd_pkg::fpd_strobe_t strobe,
   output logic [`FPD_ADDR_W-1:0] multiplexedAddress,
   input wire logic [`FPD_DATA_W-1:0] dataPinsIn,
   output logic [`FPD_DATA_W-1:0] dataPinsOut,
   output logic dataPinsOe
);
   import fpd_pkg::*;

   localparam int CYC_RCD = `FPD_CYC_MIN(`FPD_T_RCD_MIN_NS);
   localparam int CYC_RCD_MAX = `FPD_CYC_MAX(`FPD_T_RCD_MAX_NS);
   localparam int CYC_CAC = `FPD_CYC_MIN(`FPD_T_CAC_NS) + 1;
   localparam int CYC_CAS_LO = `FPD_CYC_MIN(`FPD_T_PC_NS - `FPD_T_CP_NS);
   localparam int CYC_CP = `FPD_CYC_MIN(`FPD_T_CP_NS);
   localparam int CYC_RAS = `FPD_CYC_MIN(`FPD_T_RAS_MIN_NS);
   localparam int CYC_RP = `FPD_CYC_MIN(`FPD_T_RP_NS);
   localparam int CYC_RC = `FPD_CYC_MIN(`FPD_T_RC_NS);
   localparam int CYC_CSR = `FPD_CYC_MIN(`FPD_T_CSR_NS);
   localparam int CYC_CHR = `FPD_CYC_MIN(`FPD_T_CHR_NS);
   localparam int TW = 24;

   initial begin
      if (CYC_RCD > CYC_RCD_MAX) $error("fpd_controller: clock too slow for row-to-column window");
      if (PWRUP_CYC < 1 || REF_INTERVAL_CYC < 16 || RASP_MAX_CYC < 16) $error("fpd_controller: bad counts");
      if (PWRUP_CYC >= (1 << TW) || REF_INTERVAL_CYC >= (1 << TW)) $error("fpd_controller: count too wide");
   end

   fpd_state_t state_r;
   fpd_strobe_t strobe_r;
   logic [`FPD_ADDR_W-1:0] addr_r;
   logic [`FPD_DATA_W-1:0] wdata_r, rdData_r;
   logic [9:0] openRow_r;
   logic write_r, rdValid_r, dataOe_r, initDone_r, refPending_r;
   logic [3:0] initCount_r;
   logic [TW-1:0] refTimer_r, rasTimer_r;
   logic [`FPD_DATA_W-1:0] dinMeta_r, dinSync_r;
   logic load;
   logic [TW-1:0] loadValue;
   logic done;

   fpd_delay_counter #(.WIDTH(TW)) u_delay (
      .clock(clock),
      .resetn(resetn),
      .load(load),
      .value(loadValue),
      .done(done)
   );

   // pin data is asynchronous; sample through two flops
   always_ff @(posedge clock) begin
      dinMeta_r <= dataPinsIn;
      dinSync_r <= dinMeta_r;
   end

   // refresh interval: one row every 15.6 us keeps all rows fresh in 16 ms
   always_ff @(posedge clock) begin
      if (!resetn) begin
         refTimer_r <= '0;
         refPending_r <= 1'b0;
      end else begin
         if (refTimer_r == TW'(REF_INTERVAL_CYC - 1)) begin
            refTimer_r <= '0;
         end else begin
            refTimer_r <= refTimer_r + 1'b1;
         end
         // a new tick wins over the clear
         if (initDone_r && refTimer_r == TW'(REF_INTERVAL_CYC - 1)) begin
            refPending_r <= 1'b1;
         end else if (state_r == ST_CBR_CAS) begin
            refPending_r <= 1'b0;
         end
      end
   end

   // row-active time for page mode
   always_ff @(posedge clock) begin
      if (!resetn || strobe_r.rasN) begin
         rasTimer_r <= '0;
      end else if (rasTimer_r != '1) begin
         rasTimer_r <= rasTimer_r + 1'b1;
      end
   end

   // a page hit may continue while refresh idle and row time has margin
   logic pageHit;
   assign pageHit = reqValid && !refPending_r && req.row == openRow_r
                    && rasTimer_r < TW'(RASP_MAX_CYC - 2 * CYC_RC);
   assign reqReady = (state_r == ST_IDLE && !refPending_r) || (state_r == ST_CASHI && done && pageHit);

   // main sequencer
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_r <= ST_PWRUP;
         strobe_r <= '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, oeN: 1'b1};
         addr_r <= '0;
         wdata_r <= '0;
         write_r <= 1'b0;
         dataOe_r <= 1'b0;
         openRow_r <= '0;
         initCount_r <= '0;
         initDone_r <= 1'b0;
         rdValid_r <= 1'b0;
         rdData_r <= '0;
         load <= 1'b1;
         loadValue <= TW'(PWRUP_CYC);
      end else begin
         load <= 1'b0;
         rdValid_r <= 1'b0;
         case (state_r)
            ST_PWRUP: begin
               if (done) begin
                  state_r <= ST_INIT;
               end
            end
            ST_INIT: begin
               // eight row-only cycles, write enable high
               if (done) begin
                  if (strobe_r.rasN) begin
                     if (initCount_r == 4'(`FPD_INIT_CYCLES)) begin
                        initDone_r <= 1'b1;
                        state_r <= ST_IDLE;
                     end else begin
                        strobe_r.rasN <= 1'b0;
                        load <= 1'b1;
                        loadValue <= TW'(CYC_RAS);
                     end
                  end else begin
                     strobe_r.rasN <= 1'b1;
                     initCount_r <= initCount_r + 1'b1;
                     load <= 1'b1;
                     loadValue <= TW'(CYC_RP);
                  end
               end
            end
            ST_IDLE: begin
               if (refPending_r) begin
                  // column falls first, write enable high
                  strobe_r.weN <= 1'b1;
                  strobe_r.casN <= 1'b0;
                  load <= 1'b1;
                  loadValue <= TW'(CYC_CSR);
                  state_r <= ST_CBR_CAS;
               end else if (reqValid) begin
                  // row address goes out on the same edge as the row fall
                  addr_r <= req.row;
                  openRow_r <= req.row;
                  write_r <= req.write;
                  wdata_r <= req.wdata;
                  strobe_r.rasN <= 1'b0;
                  load <= 1'b1;
                  loadValue <= TW'(CYC_RCD);
                  state_r <= ST_RAS;
                  addr_r <= req.row;
               end
            end
            ST_RAS: begin
               // column address presented now, column strobe drops on the same edge
               if (done) begin
                  addr_r <= req.col;
                  state_r <= ST_CAS;
                  strobe_r.casN <= 1'b0;
                  // early write: enable falls on the same edge as column
                  strobe_r.weN <= !write_r;
                  strobe_r.oeN <= write_r;
                  dataOe_r <= write_r;
                  load <= 1'b1;
                  loadValue <= TW'(CYC_CAS_LO > CYC_CAC ? CYC_CAS_LO : CYC_CAC);
               end
            end
            ST_CAS: begin
               // data sampled after column access time
               if (done) begin
                  if (!write_r) begin
                     rdData_r <= dinSync_r;
                     rdValid_r <= 1'b1;
                  end
                  // column rise releases device pins
                  strobe_r.casN <= 1'b1;
                  strobe_r.weN <= 1'b1;
                  strobe_r.oeN <= 1'b1;
                  dataOe_r <= 1'b0;
                  load <= 1'b1;
                  loadValue <= TW'(CYC_CP);
                  state_r <= ST_CASHI;
               end
            end
            ST_CASHI: begin
               if (done) begin
                  if (pageHit) begin
                     // page cycle keeps row low
                     addr_r <= req.col;
                     write_r <= req.write;
                     wdata_r <= req.wdata;
                     strobe_r.casN <= 1'b0;
                     strobe_r.weN <= !req.write;
                     strobe_r.oeN <= req.write;
                     dataOe_r <= req.write;
                     load <= 1'b1;
                     loadValue <= TW'(CYC_CAS_LO > CYC_CAC ? CYC_CAS_LO : CYC_CAC);
                     state_r <= ST_CAS;
                  end else if (rasTimer_r >= TW'(CYC_RAS)) begin
                     strobe_r.rasN <= 1'b1;
                     load <= 1'b1;
                     loadValue <= TW'(CYC_RC - CYC_RAS > CYC_RP ? CYC_RC - CYC_RAS : CYC_RP);
                     state_r <= ST_PRE;
                  end
               end
            end
            ST_PRE: begin
               if (done) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_CBR_CAS: begin
               if (done) begin
                  if (strobe_r.rasN) begin
                     strobe_r.rasN <= 1'b0;
                     load <= 1'b1;
                     loadValue <= TW'(CYC_RAS > CYC_CHR ? CYC_RAS : CYC_CHR);
                     state_r <= ST_CBR_RAS;
                  end
               end
            end
            ST_CBR_RAS: begin
               if (done) begin
                  strobe_r.rasN <= 1'b1;
                  strobe_r.casN <= 1'b1;
                  load <= 1'b1;
                  loadValue <= TW'(CYC_RC - CYC_RAS > CYC_RP ? CYC_RC - CYC_RAS : CYC_RP);
                  state_r <= ST_PRE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign strobe = strobe_r;
   assign multiplexedAddress = addr_r;
   assign dataPinsOut = wdata_r;
   assign dataPinsOe = dataOe_r;
   assign rdData = rdData_r;
   assign rdValid = rdValid_r;
   assign initDone = initDone_r;
endmodule : fpd_controller

// file: fpd_controller_bench.sv
// self-checking testbench for the fast-page dram controller
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmpCount++; if ((s) !== (e)) begin badCount++; $display("wrong value %s expected %h seen %h", nm, e, s); end end
module fpd_controller_bench;
   import fpd_pkg::*;
   localparam int PWRUP = 20;
   logic clock, resetn, reqValid, reqReady, rdValid, initDone, dataPinsOe;
   fpd_req_t req;
   fpd_strobe_t strobe;
   logic [3:0] rdData, dataPinsIn, dataPinsOut;
   logic [9:0] multiplexedAddress;
   int badCount = 0;
   int cmpCount = 0;
   fpd_controller #(.PWRUP_CYC(PWRUP), .REF_INTERVAL_CYC(100)) dut_u (.clock(clock), .resetn(resetn),
      .reqValid(reqValid), .reqReady(reqReady), .req(req), .rdValid(rdValid), .rdData(rdData),
      .initDone(initDone), .strobe(strobe), .multiplexedAddress(multiplexedAddress),
      .dataPinsIn(dataPinsIn), .dataPinsOut(dataPinsOut), .dataPinsOe(dataPinsOe));
   fpd_dram_model model_u (.strobe(strobe), .multiplexedAddress(multiplexedAddress),
      .dataPinsOut(dataPinsOut), .dataPinsOe(dataPinsOe), .dataPinsIn(dataPinsIn));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic endOfTest;
      $display("comparisons %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : endOfTest
   // req stays put after the handshake: the column phase reads it again
   task automatic do_req(input logic w, input logic [9:0] r, input logic [9:0] c, input logic [3:0] d);
      int n;
      n = 0;
      reqValid <= 1'b1;
      req <= {w, r, c, d};
      do begin @(negedge clock); n++; end while (reqReady !== 1'b1 && n < 300);
      `CHK("reqReady", 1'b1, reqReady)
      @(posedge clock);
      reqValid <= 1'b0;
      n = 0;
      if (!w) begin
         do begin @(negedge clock); n++; end while (rdValid !== 1'b1 && n < 40);
         `CHK("rdValid", 1'b1, rdValid)
         `CHK("rdData", d, rdData)
      end
      else repeat (4) @(negedge clock);
      @(posedge clock);
   endtask : do_req
   task automatic t_init;
      int n;
      int f0;
      n = 0;
      f0 = model_u.rasFalls;
      resetn <= 1'b0;
      repeat (5) @(posedge clock);
      `CHK("strobe in reset", 4'hF, strobe)
      `CHK("initDone in reset", 1'b0, initDone)
      resetn <= 1'b1;
      do begin @(negedge clock); n++; end while (initDone !== 1'b1 && n < 400);
      `CHK("initDone", 1'b1, initDone)
      // eight row cycles of at least 4 cycles low and 3 high follow the pause
      `CHK("power-up wait", 1'b1, n > PWRUP + 8 * 7)
      `CHK("init row cycles", 1'b1, model_u.rasFalls - f0 >= 8)
      @(posedge clock);
   endtask : t_init
   // corner rows and columns exercise every address bit both ways
   task automatic t_random;
      for (int i = 0; i < 4; i++) do_req(1'b1, 10'(i * 341), 10'(~(i * 341)), 4'(i * 5 + 3));
      for (int i = 0; i < 4; i++) do_req(1'b0, 10'(i * 341), 10'(~(i * 341)), 4'(i * 5 + 3));
   endtask : t_random
   task automatic t_page;
      for (int i = 0; i < 4; i++) do_req(1'b1, 10'h0F0, 10'(1020 + i), 4'(15 - i));
      for (int i = 0; i < 4; i++) do_req(1'b0, 10'h0F0, 10'(1020 + i), 4'(15 - i));
   endtask : t_page
   task automatic t_refresh;
      int c0;
      c0 = model_u.cbrCount;
      repeat (1000) @(posedge clock);
      `CHK("refresh count", 1'b1, model_u.cbrCount - c0 >= 9)
   endtask : t_refresh
   initial begin
      resetn = 1'b0;
      reqValid = 1'b0;
      req = '0;
      @(posedge clock);
      t_init();
      t_random();
      t_page();
      t_init();
      t_refresh();
      t_random();
      endOfTest();
   end
   initial begin
      #(25 * 20000);
      badCount++;
      endOfTest();
   end
endmodule : fpd_controller_bench

// file: fpd_controller_sva.sv
// pin-timing assertions for the fast-page dram controller
`timescale 1ns/1ps
module fpd_controller_sva #(
   parameter int RASP_MAX_CYC = 5000
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // status and pins
   input wire logic initDone,
   input wire fpd_pkg::fpd_strobe_t strobe,
   input wire logic dataPinsOe
);
   import fpd_pkg::*;
   int lowCyc_r;
   logic [3:0] rasFalls_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clock) begin
      if (!resetn || strobe.rasN) lowCyc_r <= 0;
      else lowCyc_r <= lowCyc_r + 1;
   end
   // saturates so a long run never wraps back under eight
   always_ff @(posedge clock) begin
      if (!resetn) rasFalls_r <= 4'h0;
      else if ($fell(strobe.rasN) && rasFalls_r != 4'hF) rasFalls_r <= rasFalls_r + 4'h1;
   end
   rcd_window_a: assert property (initDone && $fell(strobe.rasN) && strobe.casN |-> ##[1:2] !strobe.casN)
      else $error("column strobe not within window");
   cbr_setup_a: assert property ($fell(strobe.rasN) && !strobe.casN |-> !$past(strobe.casN))
      else $error("refresh column setup short");
   cbr_hold_a: assert property ($fell(strobe.rasN) && !strobe.casN |=> !strobe.casN)
      else $error("refresh column hold short");
   cbr_we_a: assert property ($fell(strobe.rasN) && !strobe.casN |-> strobe.weN ##1 strobe.weN)
      else $error("write enable low in refresh");
   ras_width_a: assert property ($fell(strobe.rasN) |-> !strobe.rasN [*4])
      else $error("row strobe pulse short");
   ras_precharge_a: assert property ($rose(strobe.rasN) |-> strobe.rasN [*3])
      else $error("row precharge short");
   page_cycle_a: assert property ($fell(strobe.casN) && !strobe.rasN |=> !strobe.casN)
      else $error("column cycle short");
   rasp_max_a: assert property (!strobe.rasN |-> lowCyc_r < RASP_MAX_CYC)
      else $error("row strobe held too long");
   init_count_a: assert property (initDone |-> rasFalls_r >= 4'h8)
      else $error("ready before eight row cycles");
   cover property ($fell(strobe.rasN) && !strobe.casN);
   cover property ($fell(strobe.casN) && !strobe.rasN ##[4:6] $fell(strobe.casN) && !strobe.rasN);
   cover property ($rose(dataPinsOe));
endmodule : fpd_controller_sva
bind fpd_controller fpd_controller_sva #(.RASP_MAX_CYC(RASP_MAX_CYC)) sva_u (.clock(clock), .resetn(resetn),
   .initDone(initDone), .strobe(strobe), .dataPinsOe(dataPinsOe));

// file: fpd_delay_counter.sv
// loadable down counter used for strobe phase timing; row-active time is counted apart
`timescale 1ns/1ps
module fpd_delay_counter #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // control
   input wire logic load,
   input wire logic [WIDTH-1:0] value,
   // status
   output logic done
);
   logic [WIDTH-1:0] count_r;

   initial begin
      if (WIDTH < 2) $error("fpd_delay_counter: WIDTH too small");
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         count_r <= '0;
      end else if (load) begin
         count_r <= value;
      end else if (count_r != '0) begin
         count_r <= count_r - 1'b1;
      end
   end

   // load lands a cycle late, so ending at one makes a phase last value + 1 cycles
   assign done = (count_r[WIDTH-1:1] == '0) && !load;
endmodule : fpd_delay_counter

// file: fpd_dram_model.sv
// behavioural 1M x 4 fast-page dram seen at its pins
`timescale 1ns/1ps
module fpd_dram_model (
   // dram pins
   input wire fpd_pkg::fpd_strobe_t strobe,
   input wire logic [9:0] multiplexedAddress,
   input wire logic [3:0] dataPinsOut,
   input wire logic dataPinsOe,
   output logic [3:0] dataPinsIn
);
   import fpd_pkg::*;
   logic [3:0] mem [logic [19:0]];
   logic [9:0] row = 10'h000;
   logic [3:0] shown = 4'h0;
   logic drv = 1'b0;
   int rasFalls = 0;
   int cbrCount = 0;
   // 1 ns wait lets the controller's same-edge address update land
   always @(negedge strobe.rasN) begin
      #1;
      rasFalls++;
      if (!strobe.casN) cbrCount++;
      else row = multiplexedAddress;
   end
   always @(negedge strobe.casN) begin
      drv = 1'b0;
      #1;
      if (!strobe.rasN && !strobe.weN && dataPinsOe) mem[{row, multiplexedAddress}] = dataPinsOut;
      else if (!strobe.rasN && strobe.weN) begin
         shown = mem[{row, multiplexedAddress}];
         drv <= #19 1'b1;
      end
   end
   // released pins show the inverse so stale data never passes
   assign dataPinsIn = dataPinsOe ? dataPinsOut : (drv && !strobe.casN && !strobe.oeN) ? shown : ~shown;
endmodule : fpd_dram_model

// file: fpd_map.svh
// timing constants and geometry for the fast-page dram controller
`ifndef FPD_MAP_SVH
`define FPD_MAP_SVH
`define FPD_CLK_MHZ 40
`define FPD_ADDR_W 10
`define FPD_DATA_W 4
`define FPD_ROWS 1024
`define FPD_T_RC_NS 160
`define FPD_T_PC_NS 50
`define FPD_T_RAS_MIN_NS 80
`define FPD_T_RASP_MAX_NS 125000
`define FPD_T_RCD_MIN_NS 25
`define FPD_T_RCD_MAX_NS 60
`define FPD_T_RP_NS 70
`define FPD_T_CP_NS 10
`define FPD_T_CAC_NS 20
`define FPD_T_CSR_NS 10
`define FPD_T_CHR_NS 15
`define FPD_T_REF_MS 16
`define FPD_T_PWRUP_US 100
`define FPD_INIT_CYCLES 8
`define FPD_CYC_MIN(ns) ((((ns) * `FPD_CLK_MHZ) + 999) / 1000)
`define FPD_CYC_MAX(ns) (((ns) * `FPD_CLK_MHZ) / 1000)
`endif

// file: fpd_pkg.sv
// types shared by the fast-page dram controller
package fpd_pkg;
   typedef struct packed {
      logic rasN;
      logic casN;
      logic weN;
      logic oeN;
   } fpd_strobe_t;

   typedef struct packed {
      logic write;
      logic [9:0] row;
      logic [9:0] col;
      logic [3:0] wdata;
   } fpd_req_t;

   typedef enum {ST_PWRUP, ST_INIT, ST_IDLE, ST_RAS, ST_CAS, ST_CASHI, ST_PRE,
                 ST_CBR_CAS, ST_CBR_RAS} fpd_state_t;
endpackage : fpd_pkg
